// ===== hw/dpd_device.sv
// Flash end: deep power-down entry, release and command filtering.
`timescale 1ns/1ps
module dpd_device #(
  parameter int unsigned ENTRY_CYC = dpd_pkg::ENTRY_CYC,
  parameter int unsigned RELEASE_CYC = dpd_pkg::RELEASE_CYC
) (
  // Link.
  dpd_link_if.dev link,
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Power state.
  output logic power_down,
  output logic release_busy,
  // Commands passed on in standby; soft reset from standby or power-down.
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic soft_reset
);
  localparam int unsigned TW = $clog2(((RELEASE_CYC > ENTRY_CYC) ? RELEASE_CYC : ENTRY_CYC) + 1);

  // ****************************************************************
  // Serial clock domain
  // ****************************************************************

  logic [7:0] byte_now;
  logic [3:0] bit_cnt;
  logic [7:0] op_q;
  logic len8_q;
  logic long_q;
  logic frame_tgl_q;
  logic link_clr;
  logic [1:0] lvl_m_q;
  logic [1:0] lvl_s_q;
  logic [7:0] tx_q;
  logic oe_b_q;
  logic [7:0] status_byte;

  // Opcode capture and frame tracking.
  dpd_opcode_shift u_shift (
    .sclk(link.sclk),
    .cs_b(link.cs_b),
    .mosi(link.mosi),
    .rst_b(rst_b),
    .byte_now(byte_now),
    .bit_cnt(bit_cnt),
    .op_q(op_q),
    .len8_q(len8_q),
    .long_q(long_q),
    .frame_tgl_q(frame_tgl_q)
  );

  assign link_clr = link.cs_b | ~rst_b;

  // Bring the accept level and the armed flag into the serial domain through two flops.
  logic accept_q;
  logic armed_q;
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_m_q <= 2'h0;
      lvl_s_q <= 2'h0;
    end else begin
      lvl_m_q <= {armed_q, accept_q};
      lvl_s_q <= lvl_m_q;
    end
  end

  // Status byte returned to a status read.
  always_comb begin
    status_byte = 8'h00;
    status_byte[dpd_pkg::STAT_RESET_ARMED_BIT] = lvl_s_q[1];
  end

  // Drive the return line only for a status read taken in standby.
  always_ff @(posedge link.sclk or posedge link_clr) begin
    if (link_clr) begin
      oe_b_q <= 1'b1;
    end else if (bit_cnt == dpd_pkg::BIT_IDX_LAST_OP && byte_now == dpd_pkg::OP_STATUS_READ && lvl_s_q[0]) begin
      oe_b_q <= 1'b0;
    end
  end

  // Load the status byte after the opcode and shift it out most significant bit first.
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= 8'h00;
    end else if (bit_cnt == dpd_pkg::BIT_IDX_LAST_OP) begin
      tx_q <= status_byte;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign link.miso_o = tx_q[7];
  assign link.miso_oe_b = oe_b_q;

  // ****************************************************************
  // System clock domain
  // ****************************************************************

  logic cs_m_q;
  logic cs_s_q;
  logic cs_d_q;
  logic tgl_seen_q;
  logic new_frame;
  logic frame_ok;
  logic is_pd;
  logic is_rel;
  logic is_ren;
  logic is_rst;
  logic is_ff;
  dpd_pkg::dpd_state_e state_q;
  dpd_pkg::dpd_state_e state_d;
  logic [TW-1:0] timer_q;
  logic power_down_q;
  logic release_busy_q;
  logic cmd_valid_q;
  logic [7:0] cmd_opcode_q;
  logic soft_reset_q;

  // Synchronise the select line; the second flop and a third delay flop feed the edge detect.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
    end else begin
      cs_m_q <= link.cs_b;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
    end
  end

  // A frame ends on a synchronised select rise. The serial clock has stopped by then, so the
  // captured opcode, length flags and frame toggle are stable when read here.
  assign new_frame = cs_s_q & ~cs_d_q & (frame_tgl_q != tgl_seen_q);
  assign frame_ok = new_frame & (len8_q | long_q);
  assign is_pd = (op_q == dpd_pkg::OP_POWER_DOWN);
  assign is_rel = (op_q == dpd_pkg::OP_RELEASE);
  assign is_ren = (op_q == dpd_pkg::OP_RESET_ENABLE);
  assign is_rst = (op_q == dpd_pkg::OP_RESET);
  assign is_ff = (op_q == dpd_pkg::OP_RESET_SHORT);

  // Remember the last frame toggle that was consumed.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen_q <= 1'b0;
    end else if (cs_s_q & ~cs_d_q) begin
      tgl_seen_q <= frame_tgl_q;
    end
  end

  // Next power state.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dpd_pkg::DPD_STANDBY: begin
        if (new_frame && len8_q && is_pd) begin
          state_d = dpd_pkg::DPD_ENTERING;
        end
      end
      dpd_pkg::DPD_ENTERING: begin
        if (timer_q == '0) begin
          state_d = dpd_pkg::DPD_DOWN;
        end
      end
      dpd_pkg::DPD_DOWN: begin
        if (frame_ok && is_rel) begin
          state_d = dpd_pkg::DPD_RELEASING;
        end else if (frame_ok && (is_ff || (is_rst && armed_q))) begin
          state_d = dpd_pkg::DPD_STANDBY;
        end
      end
      dpd_pkg::DPD_RELEASING: begin
        if (timer_q == '0) begin
          state_d = dpd_pkg::DPD_STANDBY;
        end
      end
      default: begin
        state_d = dpd_pkg::DPD_STANDBY;
      end
    endcase
  end

  // Power state register; reset always lands in standby.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= dpd_pkg::DPD_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // Entry and release delay timer, loaded on the state change that starts each delay.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= '0;
    end else if (state_q == dpd_pkg::DPD_STANDBY && state_d == dpd_pkg::DPD_ENTERING) begin
      timer_q <= TW'(ENTRY_CYC - 1);
    end else if (state_q == dpd_pkg::DPD_DOWN && state_d == dpd_pkg::DPD_RELEASING) begin
      timer_q <= TW'(RELEASE_CYC - 1);
    end else if (timer_q != '0) begin
      timer_q <= timer_q - TW'(1);
    end
  end

  // Reset-enable memory; ignored opcodes in the down state leave it untouched.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (frame_ok && state_q == dpd_pkg::DPD_STANDBY) begin
      armed_q <= is_ren;
    end else if (frame_ok && state_q == dpd_pkg::DPD_DOWN && (is_ren || is_rst || is_ff || is_rel)) begin
      armed_q <= is_ren;
    end
  end

  // Accept level for the serial domain: instructions are served only in standby.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      accept_q <= 1'b1;
    end else begin
      accept_q <= (state_d == dpd_pkg::DPD_STANDBY);
    end
  end

  // Pass ordinary opcodes on in standby and flag completed reset sequences.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid_q <= 1'b0;
      cmd_opcode_q <= 8'h00;
      soft_reset_q <= 1'b0;
    end else begin
      cmd_valid_q <= frame_ok && state_q == dpd_pkg::DPD_STANDBY && !is_pd && !is_ren && !is_rst && !is_ff;
      if (frame_ok && state_q == dpd_pkg::DPD_STANDBY) begin
        cmd_opcode_q <= op_q;
      end
      soft_reset_q <= frame_ok && (is_ff || (is_rst && armed_q)) &&
        (state_q == dpd_pkg::DPD_STANDBY || state_q == dpd_pkg::DPD_DOWN);
    end
  end

  // Registered power state outputs.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_down_q <= 1'b0;
      release_busy_q <= 1'b0;
    end else begin
      power_down_q <= (state_d == dpd_pkg::DPD_DOWN);
      release_busy_q <= (state_d == dpd_pkg::DPD_RELEASING);
    end
  end

  assign power_down = power_down_q;
  assign release_busy = release_busy_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_opcode = cmd_opcode_q;
  assign soft_reset = soft_reset_q;
endmodule : dpd_device

// ===== hw/dpd_host.sv
// Host end: issues opcode frames and keeps the power-up and release waits.
`timescale 1ns/1ps
module dpd_host #(
  parameter int unsigned SELECT_WAIT_CYC = dpd_pkg::SELECT_WAIT_CYC,
  parameter int unsigned WRITE_WAIT_CYC = dpd_pkg::WRITE_WAIT_CYC,
  parameter int unsigned RELEASE_WAIT_CYC = dpd_pkg::RELEASE_WAIT_CYC,
  parameter int unsigned SCLK_HALF_CYC = dpd_pkg::SCLK_HALF_CYC
) (
  // Link.
  dpd_link_if.host link,
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Request.
  input wire logic req_valid,
  input wire logic [7:0] req_opcode,
  input wire logic req_read,
  input wire logic req_write,
  output logic req_ready,
  // Answer.
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic write_ok
);
  localparam int unsigned PW = $clog2(((WRITE_WAIT_CYC > SELECT_WAIT_CYC) ? WRITE_WAIT_CYC : SELECT_WAIT_CYC) + 1);
  localparam int unsigned GW = $clog2(((RELEASE_WAIT_CYC > dpd_pkg::DESELECT_CYC) ?
    RELEASE_WAIT_CYC : dpd_pkg::DESELECT_CYC) + 1);
  localparam int unsigned HW = $clog2(SCLK_HALF_CYC + 1);

  dpd_pkg::dpd_host_state_e state_q;
  logic [PW-1:0] pu_cnt_q;
  logic write_ok_q;
  logic miso_m_q;
  logic miso_s_q;
  logic cs_q;
  logic sclk_q;
  logic mosi_q;
  logic [7:0] sh_q;
  logic [7:0] rd_q;
  logic [3:0] bits_q;
  logic [HW-1:0] hc_q;
  logic [GW-1:0] gap_q;
  logic rd_en_q;
  logic rel_q;
  logic req_ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;

  // Count time since reset release, which stands for supply reaching its minimum.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_cnt_q <= '0;
      write_ok_q <= 1'b0;
    end else begin
      if (pu_cnt_q != PW'(WRITE_WAIT_CYC) && pu_cnt_q != PW'(SELECT_WAIT_CYC) || !write_ok_q) begin
        pu_cnt_q <= (write_ok_q && pu_cnt_q >= PW'(SELECT_WAIT_CYC)) ? pu_cnt_q : pu_cnt_q + PW'(1);
      end
      if (pu_cnt_q >= PW'(WRITE_WAIT_CYC - 1)) begin
        write_ok_q <= 1'b1;
      end
    end
  end

  // Synchronise the returned data line.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_m_q <= 1'b1;
      miso_s_q <= 1'b1;
    end else begin
      miso_m_q <= link.miso;
      miso_s_q <= miso_m_q;
    end
  end

  // Frame sequencer: mode 0, data changes while the serial clock is low.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= dpd_pkg::DPD_H_POWERUP;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      bits_q <= dpd_pkg::BIT_IDX_ZERO;
      hc_q <= '0;
      gap_q <= '0;
      rd_en_q <= 1'b0;
      rel_q <= 1'b0;
      req_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        dpd_pkg::DPD_H_POWERUP: begin
          if (pu_cnt_q >= PW'(SELECT_WAIT_CYC)) begin
            state_q <= dpd_pkg::DPD_H_IDLE;
            req_ready_q <= 1'b1;
          end
        end
        dpd_pkg::DPD_H_IDLE: begin
          if (req_valid && (!req_write || write_ok_q)) begin
            state_q <= dpd_pkg::DPD_H_SHIFT;
            req_ready_q <= 1'b0;
            cs_q <= 1'b0;
            mosi_q <= req_opcode[7];
            sh_q <= {req_opcode[6:0], 1'b0};
            rd_en_q <= req_read;
            rel_q <= (req_opcode == dpd_pkg::OP_RELEASE);
            bits_q <= dpd_pkg::BIT_IDX_ZERO;
            hc_q <= '0;
          end
        end
        dpd_pkg::DPD_H_SHIFT: begin
          if (hc_q == HW'(SCLK_HALF_CYC - 1)) begin
            hc_q <= '0;
            if (!sclk_q) begin
              sclk_q <= 1'b1;
              if (bits_q >= dpd_pkg::BIT_IDX_FIRST_EXTRA) begin
                rd_q <= {rd_q[6:0], miso_s_q};
              end
            end else begin
              sclk_q <= 1'b0;
              if (bits_q == (rd_en_q ? dpd_pkg::BIT_IDX_LAST_READ : dpd_pkg::BIT_IDX_LAST_OP)) begin
                state_q <= dpd_pkg::DPD_H_END;
              end else begin
                bits_q <= bits_q + 4'h1;
                mosi_q <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
          end else begin
            hc_q <= hc_q + HW'(1);
          end
        end
        dpd_pkg::DPD_H_END: begin
          if (hc_q == HW'(SCLK_HALF_CYC - 1)) begin
            hc_q <= '0;
            cs_q <= 1'b1;
            mosi_q <= 1'b0;
            rsp_valid_q <= rd_en_q;
            rsp_data_q <= rd_q;
            gap_q <= rel_q ? GW'(RELEASE_WAIT_CYC - 1) : GW'(dpd_pkg::DESELECT_CYC - 1);
            state_q <= dpd_pkg::DPD_H_DESEL;
          end else begin
            hc_q <= hc_q + HW'(1);
          end
        end
        dpd_pkg::DPD_H_DESEL: begin
          if (gap_q == '0) begin
            state_q <= dpd_pkg::DPD_H_IDLE;
            req_ready_q <= 1'b1;
          end else begin
            gap_q <= gap_q - GW'(1);
          end
        end
        default: begin
          state_q <= dpd_pkg::DPD_H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_b = cs_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
  assign req_ready = req_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign write_ok = write_ok_q;
endmodule : dpd_host

// ===== hw/dpd_link_if.sv
// Serial link between the host end and the flash end.
`timescale 1ns/1ps
interface dpd_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe_b;
  logic miso;

  // The returned data line idles high as if pulled up when nobody drives it.
  assign miso = miso_oe_b ? 1'b1 : miso_o;

  modport host (
    output cs_b,
    output sclk,
    output mosi,
    input miso
  );

  modport dev (
    input cs_b,
    input sclk,
    input mosi,
    output miso_o,
    output miso_oe_b
  );
endinterface : dpd_link_if

// ===== hw/dpd_opcode_shift.sv
// Opcode shifter and frame tracker in the serial clock domain.
`timescale 1ns/1ps
module dpd_opcode_shift (
  // Link.
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  // Reset.
  input wire logic rst_b,
  // Frame state.
  output logic [7:0] byte_now,
  output logic [3:0] bit_cnt,
  output logic [7:0] op_q,
  output logic len8_q,
  output logic long_q,
  output logic frame_tgl_q
);
  logic [7:0] shift_q;
  logic frame_clr;
  logic [3:0] cnt_q;

  // The bit count is cleared by the frame's own select, since the clock stops between frames.
  assign frame_clr = cs_b | ~rst_b;
  assign bit_cnt = cnt_q;
  assign byte_now = {shift_q[6:0], mosi};

  // Count sampled bits in the frame, saturating past the opcode.
  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_q <= dpd_pkg::BIT_IDX_ZERO;
    end else if (cnt_q != dpd_pkg::BIT_IDX_SAT) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Shift data in, capture the opcode and record the frame length class.
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 8'h00;
      op_q <= 8'h00;
      len8_q <= 1'b0;
      long_q <= 1'b0;
      frame_tgl_q <= 1'b0;
    end else begin
      shift_q <= byte_now;
      if (cnt_q == dpd_pkg::BIT_IDX_LAST_OP) begin
        op_q <= byte_now;
      end
      len8_q <= (cnt_q == dpd_pkg::BIT_IDX_LAST_OP);
      if (cnt_q == dpd_pkg::BIT_IDX_FIRST_EXTRA) begin
        long_q <= 1'b1;
      end else if (cnt_q == dpd_pkg::BIT_IDX_ZERO) begin
        long_q <= 1'b0;
      end
      if (cnt_q == dpd_pkg::BIT_IDX_ZERO) begin
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end
endmodule : dpd_opcode_shift

// ===== hw/dpd_pkg.sv
// Shared constants and types for the deep power-down link ends.
package dpd_pkg;

  // ****************************************************************
  // Clock and opcodes
  // ****************************************************************

  // System clock rate used to turn times into cycle counts.
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned NS_PER_US = 1000;

  // Opcodes seen on the link.
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_RESET_SHORT = 8'hff;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;

  // Bit positions within a frame, counted from zero.
  localparam logic [3:0] BIT_IDX_ZERO = 4'h0;
  localparam logic [3:0] BIT_IDX_LAST_OP = 4'h7;
  localparam logic [3:0] BIT_IDX_FIRST_EXTRA = 4'h8;
  localparam logic [3:0] BIT_IDX_SAT = 4'h9;
  localparam logic [3:0] BIT_IDX_LAST_READ = 4'hf;

  // Status byte layout.
  localparam int unsigned STAT_RESET_ARMED_BIT = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************

  // Times in nanoseconds, as specified.
  localparam int unsigned POWER_DOWN_ENTRY_DELAY_NS = 3000;
  localparam int unsigned POWER_DOWN_RELEASE_DELAY_NS = 1500000;
  localparam int unsigned SUPPLY_TO_SELECT_DELAY_NS = 200000;
  localparam int unsigned POWER_UP_WRITE_DELAY_NS = 1000000;

  // Longest times round down, least times round up.
  localparam int unsigned ENTRY_CYC = POWER_DOWN_ENTRY_DELAY_NS * CLK_MHZ / NS_PER_US;
  localparam int unsigned RELEASE_CYC = POWER_DOWN_RELEASE_DELAY_NS * CLK_MHZ / NS_PER_US;
  localparam int unsigned RELEASE_WAIT_CYC = (POWER_DOWN_RELEASE_DELAY_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned SELECT_WAIT_CYC = (SUPPLY_TO_SELECT_DELAY_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int unsigned WRITE_WAIT_CYC = (POWER_UP_WRITE_DELAY_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

  // Host link pacing: half serial clock period and deselect gap in cycles.
  localparam int unsigned SCLK_HALF_CYC = 4;
  localparam int unsigned DESELECT_CYC = 8;

  // ****************************************************************
  // State types
  // ****************************************************************

  typedef enum logic [3:0] {
    DPD_STANDBY = 4'b0001,
    DPD_ENTERING = 4'b0010,
    DPD_DOWN = 4'b0100,
    DPD_RELEASING = 4'b1000
  } dpd_state_e;

  typedef enum logic [4:0] {
    DPD_H_POWERUP = 5'b00001,
    DPD_H_IDLE = 5'b00010,
    DPD_H_SHIFT = 5'b00100,
    DPD_H_END = 5'b01000,
    DPD_H_DESEL = 5'b10000
  } dpd_host_state_e;

endpackage : dpd_pkg

// ===== verif/deep_power_down_control_tb.sv
// Self-checking bench joining the host end and the flash end.
`timescale 1ns/1ps
module deep_power_down_control_tb;
  localparam int ENTRY = 10;
  localparam int REL = 50;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_opcode = 8'h00;
  logic req_read = 1'b0;
  logic req_write = 1'b0;
  logic req_ready, rsp_valid, write_ok, power_down, release_busy, cmd_valid, soft_reset, pd_b, wok;
  logic [7:0] rsp_data, cmd_opcode, got;
  int n_fail = 0;
  int check_count = 0;
  int n_cmd = 0;
  int n_soft = 0;
  int n;
  int c0;
  dpd_link_if link ();
  dpd_link_if link_b ();
  // ****
  // Ends under test
  // ****
  // Makes the 100 MHz system clock.
  always #5 sys_clk = ~sys_clk;
  dpd_host #(.SELECT_WAIT_CYC(20), .WRITE_WAIT_CYC(60), .RELEASE_WAIT_CYC(60), .SCLK_HALF_CYC(4)) i_dpd_host (
    .link(link.host), .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req_opcode(req_opcode),
    .req_read(req_read), .req_write(req_write), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .write_ok(write_ok));
  dpd_device #(.ENTRY_CYC(ENTRY), .RELEASE_CYC(REL)) i_dpd_device (.link(link.dev), .sys_clk(sys_clk),
    .rst_b(rst_b), .power_down(power_down), .release_busy(release_busy), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .soft_reset(soft_reset));
  dpd_device #(.ENTRY_CYC(ENTRY), .RELEASE_CYC(REL)) i_dpd_device_b (.link(link_b.dev), .sys_clk(sys_clk),
    .rst_b(rst_b), .power_down(pd_b), .release_busy(), .cmd_valid(), .cmd_opcode(), .soft_reset());
  dpd_link_properties #(.SELECT_WAIT_CYC(20), .RELEASE_CYC(REL)) i_dpd_link_properties (.sys_clk(sys_clk),
    .rst_b(rst_b), .cs_b(link.cs_b), .sclk(link.sclk), .mosi(link.mosi), .miso_oe_b(link.miso_oe_b));
  // Counts command and soft reset pulses.
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (soft_reset === 1'b1) n_soft <= n_soft + 1;
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // Waits a bounded time for the power state, or the release flag when rb is set, to reach a level.
  task automatic wait_pd(input logic v, input int lim, input bit rb = 1'b0);
    n = 0;
    while ((rb ? release_busy : power_down) !== v && n < lim) begin
      tick(1);
      n++;
    end
    if ((rb ? release_busy : power_down) !== v) begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_pd
  // Hands one request to the host and lets the frame finish.
  task automatic xfer(input logic [7:0] op, input logic rd, input logic wr);
    int k;
    k = 0;
    got = 8'h5a;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_opcode <= op;
    req_read <= rd;
    req_write <= wr;
    while (link.cs_b !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      wrap_up();
    end
    wok = write_ok;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do begin
      tick(1);
      k++;
      if (rsp_valid === 1'b1) got = rsp_data;
    end while (link.cs_b !== 1'b1 && k < 4000);
    if (k >= 4000) begin
      n_fail++;
      wrap_up();
    end
    tick(6);
  endtask : xfer
  // Sends a frame of nb bits on the second link, acting as a careless host.
  task automatic rg(input logic [7:0] op, input int nb);
    @(posedge sys_clk);
    link_b.cs_b <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_b.mosi <= (i < 8) ? op[7 - i] : 1'b0;
      repeat (2) @(posedge sys_clk);
      link_b.sclk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      link_b.sclk <= 1'b0;
    end
    @(posedge sys_clk);
    link_b.cs_b <= 1'b1;
    link_b.mosi <= ~link_b.mosi;
    tick(8);
  endtask : rg
  // ****
  // Scenarios
  // ****
  task automatic t_start();
    chk({7'h00, power_down}, 8'h00);
    chk({7'h00, req_ready}, 8'h00);
    xfer(8'h06, 1'b0, 1'b1);
    chk({7'h00, wok}, 8'h01);
    $display("done: power-up");
  endtask : t_start
  task automatic t_down();
    c0 = n_cmd;
    xfer(8'h05, 1'b1, 1'b0);
    chk(8'(n_cmd - c0), 8'h01);
    chk(got, 8'h00);
    chk(cmd_opcode, 8'h05);
    xfer(8'hb9, 1'b0, 1'b0);
    wait_pd(1'b1, ENTRY + 8);
    chk({7'h00, n <= ENTRY + 4}, 8'h01);
    c0 = n_cmd;
    xfer(8'h05, 1'b1, 1'b0);
    chk(got, 8'hff);
    xfer(8'h06, 1'b0, 1'b1);
    chk(8'(n_cmd - c0), 8'h00);
    chk({7'h00, power_down}, 8'h01);
    xfer(8'hab, 1'b0, 1'b0);
    chk({7'h00, release_busy}, 8'h01);
    wait_pd(1'b0, REL + 10, 1'b1);
    chk({7'h00, n >= REL - 10 && n <= REL + 4}, 8'h01);
    chk({7'h00, release_busy}, 8'h00);
    $display("done: enter and release");
  endtask : t_down
  task automatic t_resets();
    for (int s = 0; s < 2; s++) begin
      xfer(8'hb9, 1'b0, 1'b0);
      wait_pd(1'b1, ENTRY + 8);
      c0 = n_soft;
      if (s == 0) xfer(8'hff, 1'b0, 1'b0);
      else xfer(8'h66, 1'b0, 1'b0);
      if (s == 1) xfer(8'h99, 1'b0, 1'b0);
      wait_pd(1'b0, 10);
      chk(8'(n_soft - c0), 8'h01);
    end
    $display("done: reset sequences");
  endtask : t_resets
  task automatic t_rogue();
    rg(8'hb9, 9);
    tick(ENTRY + 10);
    chk({7'h00, pd_b}, 8'h00);
    rg(8'hb9, 8);
    tick(ENTRY + 10);
    chk({7'h00, pd_b}, 8'h01);
    rg(8'hab, 8);
    rg(8'hb9, 8);
    tick(REL + 2 * ENTRY);
    chk({7'h00, pd_b}, 8'h00);
    $display("done: careless host");
  endtask : t_rogue
  // Runs the scenarios after a three-cycle reset.
  initial begin
    link_b.cs_b = 1'b1;
    link_b.sclk = 1'b0;
    link_b.mosi = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(1);
    t_start();
    t_down();
    t_resets();
    t_rogue();
    wrap_up();
  end
  // Cuts a hung run short.
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
endmodule : deep_power_down_control_tb

// ===== verif/dpd_link_properties.sv
// Link protocol assertions for the deep power-down link.
`timescale 1ns/1ps
module dpd_link_properties #(
  parameter int unsigned SELECT_WAIT_CYC = 20,
  parameter int unsigned RELEASE_CYC = 50
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Link.
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe_b
);
  // ****
  // Frame tracking
  // ****
  logic sclk_q;
  logic [3:0] bits_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [15:0] gap_q;
  logic [15:0] up_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Counts serial bits in a frame and keeps its first byte.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      bits_q <= 4'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_b) begin
        bits_q <= 4'h0;
      end else if (sclk && !sclk_q) begin
        bits_q <= (bits_q == 4'hf) ? bits_q : bits_q + 4'h1;
        sh_q <= {sh_q[6:0], mosi};
        if (bits_q == 4'h7) op_q <= {sh_q[6:0], mosi};
      end
    end
  end
  // Counts deselected cycles, restarting at each frame.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) gap_q <= 16'h0000;
    else gap_q <= !cs_b ? 16'h0000 : (gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001;
  end
  // Counts cycles since power-up, saturating.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 16'h0000;
    else up_q <= (up_q == 16'hffff) ? up_q : up_q + 16'h0001;
  end
  // ****
  // Assertions
  // ****
  a_sclk_idle_low: assert property (cs_b |-> !sclk)
    else $error("serial clock active while deselected");
  a_sclk_half_len: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase has wrong length");
  a_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while serial clock high");
  a_pd_exact_len: assert property ($rose(cs_b) && op_q == 8'hb9 |-> bits_q == 4'h8)
    else $error("power-down frame not ended after eighth bit");
  a_deselect_gap: assert property ($rose(cs_b) |-> cs_b[*8])
    else $error("deselect gap too short");
  a_release_gap: assert property ($fell(cs_b) && op_q == 8'hab |-> gap_q >= RELEASE_CYC)
    else $error("select during release delay");
  a_first_select: assert property ($fell(cs_b) |-> up_q >= SELECT_WAIT_CYC)
    else $error("select too soon after power-up");
  a_miso_quiet: assert property (!miso_oe_b |-> !cs_b && bits_q >= 4'h7)
    else $error("data line driven outside a read phase");
  c_pd_frame: cover property ($rose(cs_b) && op_q == 8'hb9);
  c_rel_frame: cover property ($rose(cs_b) && op_q == 8'hab);
  c_read_drive: cover property (!miso_oe_b);
endmodule : dpd_link_properties
